// file: include/amr_consts.svh
`ifndef AMR_CONSTS_SVH
`define AMR_CONSTS_SVH

// Geometry of the mixer.
`define AMR_NCH          16
`define AMR_NPAIR        8
`define AMR_NGRP         4
`define AMR_SW           24
`define AMR_GAIN_FRAC    14

// Register map, byte addresses on an 8-bit bus address.
`define AMR_ADDR_W       8
`define AMR_IDX_PAIRTYPE 4'h0
`define AMR_IDX_EMBED    4'h1
`define AMR_IDX_STATUS   4'h2
`define AMR_IDX_IRQSTAT  4'h3
`define AMR_IDX_IRQMASK  4'h4
`define AMR_IDX_LASTMISC 4'h4
`define AMR_REG_PAIRTYPE 8'h00
`define AMR_REG_EMBED    8'h04
`define AMR_REG_STATUS   8'h08
`define AMR_REG_IRQSTAT  8'h0c
`define AMR_REG_IRQMASK  8'h10
`define AMR_REG_GAIN0    8'h40
`define AMR_REG_MODE0    8'h80
`define AMR_REG_ROUTE0   8'hc0
`define AMR_SEL_MISC     2'h0
`define AMR_SEL_GAIN     2'h1
`define AMR_SEL_MODE     2'h2
`define AMR_SEL_ROUTE    2'h3

// Gain limits and reset values, gain in whole dB.
`define AMR_GAIN_MIN     8'shba
`define AMR_GAIN_MAX     8'sh0c
`define AMR_GAIN_RST     8'sh00
`define AMR_GAIN_OFS     8'h48
`define AMR_PAIRTYPE_RST 16'h0000
`define AMR_EMBED_RST    4'h0
`define AMR_MASK_RST     4'h0

// Bus responses.
`define AMR_RESP_OKAY    2'h0
`define AMR_RESP_SLVERR  2'h2

`endif

// file: include/amr_pkg.sv
`include "amr_consts.svh"

package amr_pkg;

  // Per-channel grouping mode.
  typedef enum logic [3:0] {
    AMR_MIX_NORMAL = 4'h0,
    AMR_MIX_PAIRED = 4'h1,
    AMR_MIX_LEFT   = 4'h2,
    AMR_MIX_RIGHT  = 4'h3,
    AMR_MIX_CENTER = 4'h4,
    AMR_MIX_LSURR  = 4'h5,
    AMR_MIX_RSURR  = 4'h6,
    AMR_MIX_BASS   = 4'h7,
    AMR_MIX_LREAR  = 4'h8,
    AMR_MIX_RREAR  = 4'h9
  } amr_mode_t;

  // Content type of one incoming pair.
  typedef enum logic [1:0] {
    AMR_PT_AUDIO = 2'h0,
    AMR_PT_DATA  = 2'h1,
    AMR_PT_AUTO  = 2'h2
  } amr_ptype_t;

  // One frame of extracted samples plus its side flags.
  typedef struct packed {
    logic [`AMR_NGRP-1:0]                   grp_present;
    logic [`AMR_NPAIR-1:0]                  nonaudio;
    logic [`AMR_NCH-1:0][`AMR_SW-1:0]       smp;
  } amr_in_t;

  // One frame of mixed busses and the group insert enables.
  typedef struct packed {
    logic [`AMR_NGRP-1:0]                   grp_en;
    logic [`AMR_NCH-1:0][`AMR_SW-1:0]       smp;
  } amr_out_t;

endpackage : amr_pkg

// file: verilog/amr_gain_lut.sv
`timescale 1ns/1ps

// Converts a gain in whole dB into a linear factor with GAIN_FRAC fraction bits.
module amr_gain_lut import amr_pkg::*; (
  input  wire logic              clk_sys_i,  // System clock.
  input  wire logic signed [7:0] gain_db_i,  // Gain in dB, already clamped.
  output logic [17:0]            lin_o       // Linear factor, registered.
);

  logic [6:0]  idx;     // Gain shifted to a positive index.
  logic [3:0]  oct;     // Number of 6 dB doublings.
  logic [2:0]  rem;     // Remaining whole dB within the doubling.
  logic [14:0] frac;    // Fractional factor for the remainder.
  logic [31:0] scaled;  // Factor after the doubling shift.

  // Splits the gain into doublings and a one-dB step table.
  always_comb begin
    idx = 7'(8'(gain_db_i) + `AMR_GAIN_OFS);
    oct = 4'(idx / 7'h06);
    rem = 3'(idx % 7'h06);
    case (rem)
      3'h0:    frac = 15'h4000;
      3'h1:    frac = 15'h47cf;
      3'h2:    frac = 15'h5092;
      3'h3:    frac = 15'h5a67;
      3'h4:    frac = 15'h656f;
      3'h5:    frac = 15'h71cf;
      default: frac = 15'h4000;
    endcase
    scaled = ({17'h00000, frac} << oct) >> 12;
  end

  // The factor leaves through a register so the multiplier sees a clean value.
  always_ff @(posedge clk_sys_i) begin
    lin_o <= scaled[17:0];
  end

endmodule : amr_gain_lut

// file: verilog/amr_mixer.sv
`timescale 1ns/1ps

// Function
// - sixteen inputs, sixteen busses, any-to-any routing.
// - reset routes input n to bus n.
// - route masks allow fan-in and fan-out.
// - per-input gain -70 to +12 dB, default 0.
// - gain only at inputs, none on busses.
// - mode defaults to normal, independent gain.
// - paired mode links odd/even neighbour gains.
// - 5.1 roles form one linked group.
// - 7.1 adds two rear roles to group.
// - gain write goes to every linked member.
// - pair type audio, data or automatic.
// - report presence for each of four groups.
// - group k holds pairs 2k-1 and 2k.
// - embed group k carries enabled busses 4k-3..4k.
// - four groups of four channels handled.
module amr_mixer import amr_pkg::*; #(
  parameter int SAMPLE_W = `AMR_SW  // Sample width, fixed by the frame types.
) (
  input  wire logic                   clk_sys_i,       // System clock.
  input  wire logic                   srst_i,          // Synchronous reset, active high.
  input  wire logic [`AMR_ADDR_W-1:0] s_axi_awaddr_i,  // Write address.
  input  wire logic                   s_axi_awvalid_i, // Write address valid.
  output logic                        s_axi_awready_o, // Write address ready.
  input  wire logic [31:0]            s_axi_wdata_i,   // Write data.
  input  wire logic [3:0]             s_axi_wstrb_i,   // Write byte strobes.
  input  wire logic                   s_axi_wvalid_i,  // Write data valid.
  output logic                        s_axi_wready_o,  // Write data ready.
  output logic [1:0]                  s_axi_bresp_o,   // Write response.
  output logic                        s_axi_bvalid_o,  // Write response valid.
  input  wire logic                   s_axi_bready_i,  // Write response ready.
  input  wire logic [`AMR_ADDR_W-1:0] s_axi_araddr_i,  // Read address.
  input  wire logic                   s_axi_arvalid_i, // Read address valid.
  output logic                        s_axi_arready_o, // Read address ready.
  output logic [31:0]                 s_axi_rdata_o,   // Read data.
  output logic [1:0]                  s_axi_rresp_o,   // Read response.
  output logic                        s_axi_rvalid_o,  // Read data valid.
  input  wire logic                   s_axi_rready_i,  // Read data ready.
  input  wire logic                   in_valid_i,      // Input frame strobe.
  input  wire amr_in_t                in_i,            // Extracted frame.
  output logic                        out_valid_o,     // Output frame strobe.
  output amr_out_t                    out_o,           // Mixed frame for insertion.
  output logic                        irq_o            // Level interrupt.
);

  localparam int NCH = `AMR_NCH;
  localparam int PW  = SAMPLE_W + 4;  // Scaled sample width, gain at most four.
  localparam int AW  = PW + 4;        // Accumulator width for sixteen terms.
  localparam logic signed [AW-1:0] SMAX = AW'((64'sd1 <<< (SAMPLE_W - 1)) - 64'sd1);
  localparam logic signed [AW-1:0] SMIN = -AW'(64'sd1 <<< (SAMPLE_W - 1));

  // The frame types fix the sample width, so any other value is refused.
  if (SAMPLE_W != `AMR_SW) begin : g_bad_width
    $error("SAMPLE_W must match the frame sample width");
  end

  // Bus slave state.
  logic                   awready_q, wready_q, aw_got_q, w_got_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0]             bresp_q, rresp_q;
  logic [`AMR_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q, rdata_q;
  logic [3:0]             wstrb_q;
  // Configuration and status registers.
  logic [15:0]            ptype_q;                 // Two bits per pair.
  logic [3:0]             embed_q, mask_q, stat_q, pres_q, grp_q;
  logic signed [7:0]      gain_q  [NCH];           // Gain per input in dB.
  logic [3:0]             mode_q  [NCH];           // Grouping mode per input.
  logic [15:0]            route_q [NCH];           // Bus mask per input.
  logic                   irq_q;
  // Datapath.
  logic [17:0]            lin_w   [NCH];           // Linear gain per input.
  logic signed [PW-1:0]   prod_q  [NCH];           // Scaled samples.
  logic [SAMPLE_W-1:0]    raw_q   [NCH];           // Untouched samples.
  logic [SAMPLE_W-1:0]    bus_d   [NCH];           // Next bus values.
  logic [NCH-1:0][SAMPLE_W-1:0] bus_q;             // Bus values.
  logic [7:0]             dat_w, dat_q;            // Pair carries data.
  logic                   v1_q, v2_q;
  // Write decode.
  logic                   wr_fire, wr_ok;
  logic [1:0]             wsel;
  logic [3:0]             widx;
  logic [31:0]            wcur;                    // Current word of the written register.
  logic [15:0]            wval;
  logic signed [7:0]      gval;
  logic [3:0]             stat_clr;
  logic [3:0]             pres_ev;

  // Checks whether an address falls on a register.
  function automatic logic addr_ok(input logic [`AMR_ADDR_W-1:0] a);
    addr_ok = (a[7:6] != `AMR_SEL_MISC) || (a[5:2] <= `AMR_IDX_LASTMISC);
  endfunction : addr_ok

  // Read mux shared by reads and by byte-merged writes.
  function automatic logic [31:0] rd_word(input logic [`AMR_ADDR_W-1:0] a);
    logic [3:0] i;
    i = a[5:2];
    rd_word = 32'h00000000;
    case (a[7:6])
      `AMR_SEL_GAIN:  rd_word = {{24{gain_q[i][7]}}, gain_q[i]};
      `AMR_SEL_MODE:  rd_word = {28'h0000000, mode_q[i]};
      `AMR_SEL_ROUTE: rd_word = {16'h0000, route_q[i]};
      default: begin
        case (i)
          `AMR_IDX_PAIRTYPE: rd_word = {16'h0000, ptype_q};
          `AMR_IDX_EMBED:    rd_word = {28'h0000000, embed_q};
          `AMR_IDX_STATUS:   rd_word = {16'h0000, dat_q, 4'h0, pres_q};
          `AMR_IDX_IRQSTAT:  rd_word = {28'h0000000, stat_q};
          `AMR_IDX_IRQMASK:  rd_word = {28'h0000000, mask_q};
          default:           rd_word = 32'h00000000;
        endcase
      end
    endcase
  endfunction : rd_word

  // Write decode: data merged by byte strobes, gain clamped to its range.
  always_comb begin
    wr_fire  = aw_got_q && w_got_q;
    wr_ok    = wr_fire && addr_ok(awaddr_q);
    wsel     = awaddr_q[7:6];
    widx     = awaddr_q[5:2];
    wcur     = rd_word(awaddr_q);
    wval     = wcur[15:0];
    if (wstrb_q[0]) begin
      wval[7:0] = wdata_q[7:0];
    end
    if (wstrb_q[1]) begin
      wval[15:8] = wdata_q[15:8];
    end
    gval = $signed(wval[7:0]);
    if (gval < `AMR_GAIN_MIN) begin
      gval = `AMR_GAIN_MIN;
    end else if (gval > `AMR_GAIN_MAX) begin
      gval = `AMR_GAIN_MAX;
    end
    // Clears use the written ones only, never the merged current value.
    stat_clr = (wr_ok && wsel == `AMR_SEL_MISC && widx == `AMR_IDX_IRQSTAT && wstrb_q[0]) ?
               wdata_q[3:0] : 4'h0;
  end

  // Write channels: address and data taken in either order, response after both.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `AMR_RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && awready_q) begin
        awready_q <= 1'b0;
        aw_got_q  <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_q) begin
        wready_q <= 1'b0;
        w_got_q  <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= addr_ok(awaddr_q) ? `AMR_RESP_OKAY : `AMR_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready_i) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // Read channel: data registered on the address handshake.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h00000000;
      rresp_q   <= `AMR_RESP_OKAY;
    end else if (s_axi_arvalid_i && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_word(s_axi_araddr_i);
      rresp_q   <= addr_ok(s_axi_araddr_i) ? `AMR_RESP_OKAY : `AMR_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // Pair types, embed enables and interrupt mask.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ptype_q <= `AMR_PAIRTYPE_RST;
      embed_q <= `AMR_EMBED_RST;
      mask_q  <= `AMR_MASK_RST;
    end else if (wr_ok && wsel == `AMR_SEL_MISC) begin
      if (widx == `AMR_IDX_PAIRTYPE) begin
        ptype_q <= wval;
      end
      if (widx == `AMR_IDX_EMBED) begin
        embed_q <= wval[3:0];
      end
      if (widx == `AMR_IDX_IRQMASK) begin
        mask_q <= wval[3:0];
      end
    end
  end

  // Group presence is tracked every cycle; a change of any group is an event.
  assign pres_ev = in_i.grp_present ^ pres_q;

  // Presence status, sticky events and the interrupt; a new event beats a clear.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      pres_q <= 4'h0;
      stat_q <= 4'h0;
      irq_q  <= 1'b0;
    end else begin
      pres_q <= in_i.grp_present;
      stat_q <= (stat_q & ~stat_clr) | pres_ev;
      irq_q  <= |(stat_q & mask_q);
    end
  end

  // Pair content: forced audio, forced data, or the extractor's non-audio flag.
  generate
    for (genvar p = 0; p < `AMR_NPAIR; p++) begin : g_pair
      assign dat_w[p] = (ptype_q[2*p+:2] == AMR_PT_DATA) ||
                        ((ptype_q[2*p+:2] == AMR_PT_AUTO) && in_i.nonaudio[p]);
    end
  endgenerate

  // Per-input channel: its settings, its gain converter and its scaling stage.
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic hit;  // This channel takes the gain being written.
      logic signed [SAMPLE_W+18:0] mul;  // Full product, wide enough for the largest gain.

      // The product is formed at full width so a high gain cannot wrap before scaling.
      assign mul = $signed(in_i.smp[c]) * $signed({1'b0, lin_w[c]});

      // A write reaches the channel itself, its paired neighbour, or the whole surround set.
      always_comb begin
        hit = wr_ok && (wsel == `AMR_SEL_GAIN) &&
              ((widx == 4'(c)) ||
               ((widx == 4'(c ^ 1)) &&
                ((mode_q[c] == AMR_MIX_PAIRED) || (mode_q[widx] == AMR_MIX_PAIRED))) ||
               ((mode_q[c] >= AMR_MIX_LEFT) && (mode_q[c] <= AMR_MIX_RREAR) &&
                (mode_q[widx] >= AMR_MIX_LEFT) && (mode_q[widx] <= AMR_MIX_RREAR)));
      end

      // Gain, mode and route of this channel.
      always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
          gain_q[c]  <= `AMR_GAIN_RST;
          mode_q[c]  <= AMR_MIX_NORMAL;
          route_q[c] <= 16'(32'h1 << c);
        end else begin
          if (hit) begin
            gain_q[c] <= gval;
          end
          if (wr_ok && wsel == `AMR_SEL_MODE && widx == 4'(c)) begin
            mode_q[c] <= wval[3:0];
          end
          if (wr_ok && wsel == `AMR_SEL_ROUTE && widx == 4'(c)) begin
            route_q[c] <= wval;
          end
        end
      end

      amr_gain_lut u_lut (
        .clk_sys_i (clk_sys_i),
        .gain_db_i (gain_q[c]),
        .lin_o     (lin_w[c])
      );

      // Input gain stage; the raw word is kept for data pairs.
      always_ff @(posedge clk_sys_i) begin
        prod_q[c] <= PW'(mul >>> `AMR_GAIN_FRAC);
        raw_q[c]  <= in_i.smp[c];
      end
    end
  endgenerate

  // Per-output bus: sum of routed audio, or the first routed data word unchanged.
  generate
    for (genvar b = 0; b < NCH; b++) begin : g_bus
      logic signed [AW-1:0] acc;   // Sum of scaled audio.
      logic                 hasd;  // A data input is routed here.
      logic [SAMPLE_W-1:0]  rsel;  // The data word chosen.

      always_comb begin
        acc  = '0;
        hasd = 1'b0;
        rsel = '0;
        for (int c = 0; c < NCH; c++) begin
          if (route_q[c][b]) begin
            if (dat_q[c/2]) begin
              if (!hasd) begin
                rsel = raw_q[c];
                hasd = 1'b1;
              end
            end else begin
              acc = acc + AW'(prod_q[c]);
            end
          end
        end
        if (hasd) begin
          bus_d[b] = rsel;
        end else if (acc > SMAX) begin
          bus_d[b] = SMAX[SAMPLE_W-1:0];
        end else if (acc < SMIN) begin
          bus_d[b] = SMIN[SAMPLE_W-1:0];
        end else begin
          bus_d[b] = acc[SAMPLE_W-1:0];
        end
      end
    end
  endgenerate

  // Pipeline strobes and flags.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      v1_q  <= 1'b0;
      v2_q  <= 1'b0;
      dat_q <= 8'h00;
      grp_q <= 4'h0;
    end else begin
      v1_q <= in_valid_i;
      v2_q <= v1_q;
      if (in_valid_i) begin
        dat_q <= dat_w;
      end
      grp_q <= v1_q ? embed_q : 4'h0;
    end
  end

  // Bus outputs, one register per bus.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      bus_q <= '0;
    end else begin
      for (int b = 0; b < NCH; b++) begin
        bus_q[b] <= bus_d[b];
      end
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o  = wready_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;
  assign out_valid_o     = v2_q;
  assign out_o           = {grp_q, bus_q};
  assign irq_o           = irq_q;

  a_route_default: assert property (@(posedge clk_sys_i) $fell(srst_i) |->
    (route_q[0] == 16'h0001) && (route_q[9] == 16'h0200) && (route_q[15] == 16'h8000))
    else $error("route not one-to-one after reset");
  a_gain_range: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (gain_q[3] >= `AMR_GAIN_MIN) && (gain_q[3] <= `AMR_GAIN_MAX))
    else $error("gain out of range");
  a_mode_reset: assert property (@(posedge clk_sys_i) $fell(srst_i) |->
    (mode_q[5] == AMR_MIX_NORMAL) && (gain_q[5] == `AMR_GAIN_RST))
    else $error("mode or gain not default after reset");
  a_pair_linked: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_ok && wsel == `AMR_SEL_GAIN && (widx == 4'h8 || widx == 4'h9) &&
     (mode_q[8] == AMR_MIX_PAIRED || mode_q[9] == AMR_MIX_PAIRED)) |=>
    (gain_q[9] == gain_q[8]))
    else $error("paired gain not shared");
  a_surr_linked: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (wr_ok && wsel == `AMR_SEL_GAIN && widx == 4'hc && mode_q[8] == AMR_MIX_LEFT &&
     mode_q[15] == AMR_MIX_RREAR && mode_q[12] >= AMR_MIX_LEFT && mode_q[12] <= AMR_MIX_RREAR) |=>
    (gain_q[8] == gain_q[12]) && (gain_q[15] == gain_q[12]))
    else $error("surround gain not shared");
  a_out_latency: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    in_valid_i |-> ##2 out_valid_o)
    else $error("output frame not two cycles after input");
  a_embed_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    out_valid_o |-> (out_o.grp_en == $past(embed_q)))
    else $error("embed enables not applied");
  a_data_exact: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (v1_q && dat_q[1] && !dat_q[0] && route_q[2][2]) |=> (bus_q[2] == $past(raw_q[2])))
    else $error("data word altered");
  a_sum_sat: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (!g_bus[0].hasd && g_bus[0].acc > SMAX) |=> (bus_q[0] == SMAX[SAMPLE_W-1:0]))
    else $error("bus sum not saturated");
  a_presence_evt: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    (in_i.grp_present[2] != pres_q[2]) |=> stat_q[2] ##1 (irq_o == mask_q[2]))
    else $error("presence change not flagged");

endmodule : amr_mixer

// file: testbench/amr_far_model.sv
`timescale 1ns/1ps

// Stand-in for the extraction and insertion logic on the mixer's far side.
module amr_far_model import amr_pkg::*; (
  input  wire logic     clk_sys_i,   // System clock.
  input  wire logic     srst_i,      // Synchronous reset, active high.
  input  wire logic     req_i,       // Send the staged frame.
  input  wire amr_in_t  frame_i,     // Frame staged by the bench.
  input  wire logic     out_valid_i, // Mixed frame strobe.
  input  wire amr_out_t out_i,       // Mixed frame.
  output logic          in_valid_o,  // Frame strobe to the mixer.
  output amr_in_t       in_o,        // Frame to the mixer.
  output amr_out_t      cap_o,       // Last mixed frame taken.
  output logic [7:0]    ncap_o       // Count of mixed frames taken.
);
  // Samples invert between frames, so a stale frame never looks like a fresh one.
  always_ff @(posedge clk_sys_i) begin
    in_valid_o       <= req_i & ~srst_i;
    in_o.grp_present <= frame_i.grp_present;
    in_o.nonaudio    <= frame_i.nonaudio;
    in_o.smp         <= req_i ? frame_i.smp : ~in_o.smp;
  end

  // The insertion side takes every mixed frame, keeps the last one and counts it.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ncap_o <= 8'h00;
    end else if (out_valid_i) begin
      cap_o  <= out_i;
      ncap_o <= ncap_o + 8'h01;
    end
  end
endmodule : amr_far_model

// file: testbench/tb.sv
`timescale 1ns/1ps

// Self-checking bench: bus master tasks and frame traffic through the far-side model.
module tb import amr_pkg::*; ;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} amr_row_t;  // Write, read back.
  logic        clk_sys_i = 1'h0;  // System clock.
  logic        srst_i    = 1'h1;  // Reset, held at start.
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ncap;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, req = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid, out_valid, in_valid, irq;
  logic [1:0]  bresp, rresp;
  amr_in_t     fr = '0, in_d;
  amr_out_t    out_d, cap;
  int          n_errors = 0, checked = 0, n;
  amr_row_t    rows [12] = '{'{8'h40, 32'h7f, 32'hc}, '{8'h44, 32'h80, 32'hffffffba},
    '{8'h44, 32'hba, 32'hffffffba}, '{8'h40, 32'h0, 32'h0}, '{8'h44, 32'h0, 32'h0}, '{8'h84, 32'h9, 32'h9},
    '{8'h84, 32'h0, 32'h0}, '{8'hc4, 32'hffff, 32'hffff}, '{8'hc4, 32'h2, 32'h2},
    '{8'h00, 32'hffff1234, 32'h1234}, '{8'h00, 32'h0, 32'h0}, '{8'h10, 32'hf, 32'hf}};

  amr_mixer u_amr_mixer (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .in_valid_i(in_valid), .in_i(in_d), .out_valid_o(out_valid), .out_o(out_d), .irq_o(irq));
  amr_far_model u_amr_far_model (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_i(req), .frame_i(fr),
    .out_valid_i(out_valid), .out_i(out_d), .in_valid_o(in_valid), .in_o(in_d), .cap_o(cap), .ncap_o(ncap));

  // 200 MHz clock.
  always #2.5 clk_sys_i = ~clk_sys_i;

  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  // A wait that ran out counts as a mismatch and closes the run.
  task automatic give_up();
    n_errors++;
    complete_run();
  endtask : give_up

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One write: both channels offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `AMR_RESP_OKAY);
    int k;
    @(posedge clk_sys_i);  // An edge between calls, so no signal is set twice in one step.
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_i);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) begin
        bready <= 1'h0;
        chk(32'(bresp), 32'(er));
        break;
      end
    end
    if (k == 50) give_up();
  endtask : wr

  // One read, compared with the expected word and response.
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `AMR_RESP_OKAY);
    int k;
    @(posedge clk_sys_i);  // An edge between calls, so no signal is set twice in one step.
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_sys_i);
      if (arready) arvalid <= 1'h0;
      if (rvalid) begin
        rready <= 1'h0;
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
        break;
      end
    end
    if (k == 50) give_up();
  endtask : rc

  // Sends the staged frame and waits for its mixed result.
  task automatic mix();
    logic [7:0] n0;
    int         k;
    n0 = ncap;
    @(posedge clk_sys_i);
    req <= 1'h1;
    @(posedge clk_sys_i);
    req <= 1'h0;
    for (k = 0; k < 20 && ncap == n0; k++) @(posedge clk_sys_i);
    if (ncap == n0) give_up();
  endtask : mix

  // Checks one output bus of the last mixed frame.
  task automatic cb(input int b, input logic [23:0] e);
    chk({8'h00, cap.smp[b]}, {8'h00, e});
  endtask : cb

  // Main sequence: reset state, register rows, then hand-written cases.
  initial begin
    repeat (10) @(posedge clk_sys_i);
    srst_i <= 1'h0;
    for (n = 0; n < 16; n++) begin
      rc(8'hc0 + 8'(4 * n), 32'h1 << n);
      rc(8'h40 + 8'(4 * n), 32'h0);
      rc(8'h80 + 8'(4 * n), 32'h0);
    end
    $display("reset state done");
    for (n = 0; n < 12; n++) begin
      wr(rows[n].a, rows[n].d);
      rc(rows[n].a, rows[n].e);
    end
    wr(8'h10, 32'h0);
    wr(8'h14, 32'h1, `AMR_RESP_SLVERR);
    rc(8'h14, 32'h0, `AMR_RESP_SLVERR);
    $display("register rows done");
    for (n = 0; n < 16; n++)
      fr.smp[n] <= 24'h010101 * 24'(n) + 24'h1;
    mix();
    for (n = 0; n < 16; n++)
      cb(n, 24'h010101 * 24'(n) + 24'h1);
    chk(32'(cap.grp_en), 32'h0);
    wr(8'h04, 32'h5);
    mix();
    chk(32'(cap.grp_en), 32'h5);
    wr(8'h04, 32'h0);
    $display("straight through and embed done");
    wr(8'hc4, 32'h3);
    wr(8'h44, 32'h6);
    fr.smp[0] <= 24'h600000;
    fr.smp[1] <= 24'h200000;
    mix();
    cb(0, 24'h7fffff);
    cb(1, 24'h400000);
    cb(2, 24'h020203);
    wr(8'hc4, 32'h2);
    wr(8'h44, 32'h0);
    $display("fan-in and gain done");
    wr(8'ha0, 32'h1);
    wr(8'h64, 32'hc);
    rc(8'h60, 32'hc);
    wr(8'ha0, 32'h0);
    wr(8'h64, 32'h0);
    rc(8'h60, 32'hc);
    for (n = 8; n < 16; n++)
      wr(8'h40 + 8'(4 * n) + 8'h40, 32'(n - 6));
    wr(8'h70, 32'hfa);
    for (n = 8; n < 16; n++)
      rc(8'h40 + 8'(4 * n), 32'hfffffffa);
    rc(8'h5c, 32'h0);
    $display("linking done");
    wr(8'h00, 32'h4);
    wr(8'h48, 32'hc);
    fr.smp[2] <= 24'h812345;
    mix();
    cb(2, 24'h812345);
    wr(8'h00, 32'h8);
    fr.nonaudio <= 8'h02;
    mix();
    cb(2, 24'h812345);
    fr.nonaudio <= 8'h00;
    fr.smp[2] <= 24'h000123;
    mix();
    cb(2, 24'h00048c);
    $display("data pairs done");
    fr.grp_present <= 4'h4;
    repeat (3) @(posedge clk_sys_i);
    rc(8'h0c, 32'h4);
    chk(32'(irq), 32'h0);
    wr(8'h10, 32'h4);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq), 32'h1);
    rc(8'h08, 32'h4);
    wr(8'h0c, 32'h4);
    repeat (2) @(posedge clk_sys_i);
    chk(32'(irq), 32'h0);
    rc(8'h0c, 32'h0);
    $display("presence interrupt done");
    complete_run();
  end
endmodule : tb
